// ===== hdl/cpsc_ctrl.v
`timescale 1ns/1ns
`include "cpsc_consts.vh"
// Function
// - no fault: charge and discharge enabled
// - overcharge held for delay: stop charging
// - below release voltage: leave overcharge
// - discharging starts: leave overcharge
// - undervoltage held for delay: stop discharging
// - pull-up on in overdischarge, power-down
// - power-down 1.5 s after overdischarge
// - charger detected: leave power-down
// - switch stays off until cell recovers
// - above release voltage: back to normal
// - overcurrent held for delay: stop discharging
// - load short: discharge off within delay
// - pull-down on in overcurrent
// - load removed: leave overcurrent
// - abnormal charge held: stop charging
// - three ship pulses: deep sleep
// - charger detected with no overcharge, overdischarge or short wakes sleep
module cpsc_ctrl #(
  parameter OVCHG_CYC = `CPSC_OVCHG_CYC,
  parameter OVDIS_CYC = `CPSC_OVDIS_CYC,
  parameter OVCUR_CYC = `CPSC_OVCUR_CYC,
  parameter ABCHG_CYC = `CPSC_ABCHG_CYC,
  parameter SHORT_CYC = `CPSC_SHORT_CYC,
  parameter PDOWN_CYC = `CPSC_PDOWN_CYC
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // comparator flags, asynchronous
  input wire cell_above_ovchg,
  input wire cell_below_ovchg_rel,
  input wire cell_below_ovdis,
  input wire cell_above_ovdis_rel,
  input wire sense_above_ovcur,
  input wire sense_load_short,
  input wire sense_below_chg_det,
  input wire charger_detect,
  input wire charging,
  input wire discharging,
  // ship-mode pin, open drain from host, read only
  input wire ship_mode_pin_in,
  // switch and pin controls
  output reg chg_en_reg,
  output reg dis_en_reg,
  output reg pullup_en_reg,
  output reg pulldown_en_reg,
  output reg power_down_reg,
  output reg deep_sleep_reg,
  output reg [5:0] state_out_reg
);
  localparam W = `CPSC_CNT_W;
  localparam [5:0] ST_NORM = 6'h01;
  localparam [5:0] ST_OVCHG = 6'h02;
  localparam [5:0] ST_OVDIS = 6'h04;
  localparam [5:0] ST_PDOWN = 6'h08;
  localparam [5:0] ST_OVCUR = 6'h10;
  localparam [5:0] ST_SLEEP = 6'h20;
  localparam [1:0] SHIP_N = `CPSC_SHIP_PULSES;

  // two-flop synchronisers, first stage read only by second
  reg [10:0] s1_reg;
  reg [10:0] s2_reg;
  wire [10:0] raw = {ship_mode_pin_in, discharging, charging, charger_detect, sense_below_chg_det,
    sense_load_short, sense_above_ovcur, cell_above_ovdis_rel, cell_below_ovdis,
    cell_below_ovchg_rel, cell_above_ovchg};
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 11'h400;
      s2_reg <= 11'h400;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end
  wire ovchg = s2_reg[0];
  wire ovchg_rel = s2_reg[1];
  wire ovdis = s2_reg[2];
  wire ovdis_rel = s2_reg[3];
  wire ovcur = s2_reg[4];
  wire lshort = s2_reg[5];
  wire below_det = s2_reg[6];
  wire chg_det = s2_reg[7];
  wire chg_act = s2_reg[8];
  wire dis_act = s2_reg[9];
  wire ship = s2_reg[10];

  reg [5:0] state_reg;
  reg [5:0] state_next;
  reg ship_d_reg;
  reg [1:0] pulse_cnt_reg;
  reg chg_block_reg;
  wire ship_fall = ship_d_reg & ~ship;
  wire in_norm = state_reg == ST_NORM;

  wire t_ovchg;
  wire t_ovdis;
  wire t_ovcur;
  wire t_abchg;
  wire t_short;
  wire t_pdown;
  cpsc_delay_timer #(.W(W)) u_ovchg (.sys_clk(sys_clk), .rst_n(rst_n),
    .cond(in_norm & chg_act & ovchg), .limit(OVCHG_CYC[W-1:0]), .expired_reg(t_ovchg));
  cpsc_delay_timer #(.W(W)) u_ovdis (.sys_clk(sys_clk), .rst_n(rst_n),
    .cond(in_norm & dis_act & ovdis), .limit(OVDIS_CYC[W-1:0]), .expired_reg(t_ovdis));
  cpsc_delay_timer #(.W(W)) u_ovcur (.sys_clk(sys_clk), .rst_n(rst_n),
    .cond(in_norm & dis_act & ovcur), .limit(OVCUR_CYC[W-1:0]), .expired_reg(t_ovcur));
  cpsc_delay_timer #(.W(W)) u_abchg (.sys_clk(sys_clk), .rst_n(rst_n),
    .cond(in_norm & chg_act & below_det), .limit(ABCHG_CYC[W-1:0]), .expired_reg(t_abchg));
  // short delay, shorter than the limit max
  cpsc_delay_timer #(.W(W)) u_short (.sys_clk(sys_clk), .rst_n(rst_n),
    .cond(in_norm & lshort), .limit(SHORT_CYC[W-1:0]), .expired_reg(t_short));
  cpsc_delay_timer #(.W(W)) u_pdown (.sys_clk(sys_clk), .rst_n(rst_n),
    .cond(state_reg == ST_OVDIS), .limit(PDOWN_CYC[W-1:0]), .expired_reg(t_pdown));

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_NORM: begin
        if (ship_fall && pulse_cnt_reg == SHIP_N - 2'h1)
          state_next = ST_SLEEP;
        else if (t_short || t_ovcur)
          state_next = ST_OVCUR;
        else if (t_ovdis)
          state_next = ST_OVDIS;
        else if (t_ovchg)
          state_next = ST_OVCHG;
      end
      ST_OVCHG: begin
        if (ovchg_rel || dis_act)
          state_next = ST_NORM;
      end
      ST_OVDIS: begin
        if (ovdis_rel)
          state_next = ST_NORM;
        else if (t_pdown)
          state_next = ST_PDOWN;
      end
      ST_PDOWN: begin
        if (chg_det)
          state_next = ST_OVDIS;
      end
      ST_OVCUR: begin
        if (!ovcur && !lshort)
          state_next = ST_NORM;
      end
      ST_SLEEP: begin
        if (chg_det && !ovdis && !ovchg && !lshort)
          state_next = ST_NORM;
      end
      default: state_next = ST_NORM;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_NORM;
      ship_d_reg <= 1'b1;
      pulse_cnt_reg <= 2'h0;
      chg_block_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ship_d_reg <= ship;
      // pulses count only in normal; any other state forgets them
      if (!in_norm)
        pulse_cnt_reg <= 2'h0;
      else if (ship_fall)
        pulse_cnt_reg <= pulse_cnt_reg + 2'h1;
      if (t_abchg)
        chg_block_reg <= 1'b1;
      else if (!chg_det && !chg_act)
        chg_block_reg <= 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_en_reg <= 1'b1;
      dis_en_reg <= 1'b1;
      pullup_en_reg <= 1'b0;
      pulldown_en_reg <= 1'b0;
      power_down_reg <= 1'b0;
      deep_sleep_reg <= 1'b0;
      state_out_reg <= ST_NORM;
    end else begin
      chg_en_reg <= (state_next == ST_NORM || state_next == ST_OVCUR) && !chg_block_reg && !t_abchg;
      dis_en_reg <= state_next == ST_NORM || state_next == ST_OVCHG;
      pullup_en_reg <= state_next == ST_OVDIS || state_next == ST_PDOWN;
      pulldown_en_reg <= state_next == ST_OVCUR;
      power_down_reg <= state_next == ST_PDOWN;
      deep_sleep_reg <= state_next == ST_SLEEP;
      state_out_reg <= state_next;
    end
  end
endmodule // cpsc_ctrl

// ===== hdl/cpsc_consts.vh
`ifndef CPSC_CONSTS_VH
`define CPSC_CONSTS_VH
// clock rate in kHz
`define CPSC_CLK_KHZ 250000
// detection delays in their own units (nominal)
`define CPSC_OVCHG_MS 100
`define CPSC_OVDIS_MS 80
`define CPSC_OVCUR_MS 10
`define CPSC_ABCHG_MS 12
`define CPSC_SHORT_US 180
`define CPSC_PDOWN_MS 1500
// cycle counts derived from the rate
`define CPSC_OVCHG_CYC (`CPSC_OVCHG_MS * `CPSC_CLK_KHZ)
`define CPSC_OVDIS_CYC (`CPSC_OVDIS_MS * `CPSC_CLK_KHZ)
`define CPSC_OVCUR_CYC (`CPSC_OVCUR_MS * `CPSC_CLK_KHZ)
`define CPSC_ABCHG_CYC (`CPSC_ABCHG_MS * `CPSC_CLK_KHZ)
`define CPSC_SHORT_CYC ((`CPSC_SHORT_US * `CPSC_CLK_KHZ) / 1000)
`define CPSC_PDOWN_CYC (`CPSC_PDOWN_MS * `CPSC_CLK_KHZ)
// ship-mode pulse count
`define CPSC_SHIP_PULSES 3
`define CPSC_CNT_W 32
`endif

// ===== hdl/cpsc_delay_timer.v
`timescale 1ns/1ns
// qualifies a level: fires once the level has held for limit cycles
module cpsc_delay_timer #(
  parameter W = 32
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // level and limit
  input wire cond,
  input wire [W-1:0] limit,
  // qualified output
  output reg expired_reg
);
  reg [W-1:0] cnt_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= {W{1'b0}};
      expired_reg <= 1'b0;
    end else if (!cond) begin
      cnt_reg <= {W{1'b0}};
      expired_reg <= 1'b0;
    end else if (cnt_reg + {{(W-1){1'b0}}, 1'b1} >= limit) begin
      expired_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // cpsc_delay_timer

// ===== test/cpsc_ctrl_props.sv
`timescale 1ns/1ns
module cpsc_ctrl_props (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // flags
  input wire sense_above_ovcur,
  input wire sense_load_short,
  input wire discharging,
  // controls
  input wire chg_en_reg,
  input wire dis_en_reg,
  input wire pullup_en_reg,
  input wire pulldown_en_reg,
  input wire power_down_reg,
  input wire deep_sleep_reg,
  input wire [5:0] state_out_reg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire st_nrm = state_out_reg == 6'h01;
  wire st_och = state_out_reg == 6'h02;
  wire st_odis = state_out_reg == 6'h04;
  wire st_ocur = state_out_reg == 6'h10;
  sequence ovdis_entry; $rose(st_odis); endsequence
  sequence short_held; (st_nrm && sense_load_short && discharging)[*8]; endsequence
  sequence load_gone; (!sense_above_ovcur && !sense_load_short)[*6]; endsequence
  normal_dis_on_a: assert property (
    st_nrm |-> dis_en_reg) else $error("discharge off in normal");
  ovchg_off_a: assert property (
    st_och |-> !chg_en_reg && dis_en_reg) else $error("overcharge enables wrong");
  ovchg_leave_a: assert property (
    st_och ##1 discharging[*6] |-> ##[0:2] !st_och) else $error("overcharge kept");
  ovdis_pullup_a: assert property (
    st_odis || power_down_reg |-> pullup_en_reg && !dis_en_reg) else $error("pull-up off");
  pdown_delay_a: assert property (
    ovdis_entry |-> !power_down_reg[*8] ##[1:40] (power_down_reg || !st_odis)) else $error("power-down time");
  short_trip_a: assert property (
    short_held |-> ##[0:3] !dis_en_reg) else $error("short not cut");
  ovcur_pull_a: assert property (
    st_ocur |-> pulldown_en_reg && !dis_en_reg) else $error("pull-down off");
  ovcur_rel_a: assert property (
    st_ocur ##1 load_gone |-> ##[0:2] st_nrm) else $error("overcurrent kept");
  sleep_off_a: assert property (
    deep_sleep_reg |-> !chg_en_reg && !dis_en_reg) else $error("switch on in sleep");
endmodule // cpsc_ctrl_props
bind cpsc_ctrl cpsc_ctrl_props chk_u (.sys_clk, .rst_n, .sense_above_ovcur, .sense_load_short, .discharging,
  .chg_en_reg, .dis_en_reg, .pullup_en_reg, .pulldown_en_reg, .power_down_reg, .deep_sleep_reg, .state_out_reg);

// ===== test/cpsc_cell_model.sv
`timescale 1ns/1ns
// load_kind: 0 idle, 1 load, 2 overload, 3 short, 4 charger, 5 faulty charger
module cpsc_cell_model #(
  parameter OC_MV = 4280,
  parameter OCR_MV = 4080,
  parameter OD_MV = 2800,
  parameter ODR_MV = 3000
) (
  // cell and load
  input wire [15:0] cell_mv,
  input wire [2:0] load_kind,
  // comparator levels
  output wire cell_above_ovchg,
  output wire cell_below_ovchg_rel,
  output wire cell_below_ovdis,
  output wire cell_above_ovdis_rel,
  output wire sense_above_ovcur,
  output wire sense_load_short,
  output wire sense_below_chg_det,
  output wire charger_detect,
  output wire charging,
  output wire discharging
);
  assign cell_above_ovchg = cell_mv > OC_MV;
  assign cell_below_ovchg_rel = cell_mv < OCR_MV;
  assign cell_below_ovdis = cell_mv < OD_MV;
  assign cell_above_ovdis_rel = cell_mv >= ODR_MV;
  // a short also lifts the sense level past the overcurrent point
  assign sense_above_ovcur = load_kind == 3'h2 || load_kind == 3'h3;
  assign sense_load_short = load_kind == 3'h3;
  assign sense_below_chg_det = load_kind == 3'h5;
  assign charger_detect = load_kind >= 3'h4;
  assign charging = load_kind >= 3'h4;
  assign discharging = load_kind != 3'h0 && load_kind < 3'h4;
endmodule // cpsc_cell_model

// ===== test/tb.sv
`timescale 1ns/1ns
module tb;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg ship_mode_pin_in = 1'b1;
  reg [15:0] cell_mv = 16'h0E10;
  reg [2:0] load_kind = 3'h0;
  reg [31:0] seed = 32'hA7337F8C;
  integer n_mismatch = 0;
  integer checks_done = 0;
  integer i;
  wire cell_above_ovchg, cell_below_ovchg_rel, cell_below_ovdis, cell_above_ovdis_rel, sense_above_ovcur;
  wire sense_load_short, sense_below_chg_det, charger_detect, charging, discharging;
  wire chg_en_reg, dis_en_reg, pullup_en_reg, pulldown_en_reg, power_down_reg, deep_sleep_reg;
  wire [5:0] state_out_reg;
  cpsc_cell_model model_u (.*);
  // short delay keeps its nominal count; the quick overcurrent count cuts a short first in this run
  cpsc_ctrl #(.OVCHG_CYC(20), .OVDIS_CYC(16), .OVCUR_CYC(4), .ABCHG_CYC(10), .PDOWN_CYC(30))
    dut_u (.*);
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], ^(s & 32'h80200003)};
  endfunction
  // {chg, dis, pull-up, pull-down, power-down, sleep}
  function [5:0] outs(input [5:0] st, input c);
    outs = {c, st == 6'h01 || st == 6'h02, st[2] | st[3], st[4], st[3], st[5]};
  endfunction
  task chk(input [5:0] seen, input [5:0] want);
    begin
      checks_done = checks_done + 1;
      if (seen !== want) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  task step(input [15:0] mv, input [2:0] ld, input integer n, input [5:0] st, input c);
    begin
      cell_mv = mv;
      load_kind = ld;
      repeat (n) @(posedge sys_clk);
      #1;
      chk(state_out_reg, st);
      chk({chg_en_reg, dis_en_reg, pullup_en_reg, pulldown_en_reg, power_down_reg,
        deep_sleep_reg}, outs(st, c));
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    step(16'h0E10, 3'h0, 4, 6'h01, 1'b1);
    for (i = 0; i < 30; i = i + 1) begin
      seed = nxt(seed);
      step(16'h0C1C + {6'h00, seed[9:0]}, {2'h0, seed[10]}, 3, 6'h01, 1'b1);
    end
    for (i = 0; i < 2; i = i + 1) begin
      step(16'h10CC, 3'h4, 15, 6'h01, 1'b1);
      step(16'h0E10, 3'h4, 3, 6'h01, 1'b1);
    end
    step(16'h10CC, 3'h4, 30, 6'h02, 1'b0);
    step(16'h0FA0, 3'h4, 8, 6'h01, 1'b1);
    step(16'h10CC, 3'h4, 30, 6'h02, 1'b0);
    step(16'h10CC, 3'h1, 8, 6'h01, 1'b1);
    step(16'h0A8C, 3'h1, 30, 6'h04, 1'b0);
    step(16'h0A8C, 3'h0, 45, 6'h08, 1'b0);
    step(16'h0A8C, 3'h4, 8, 6'h04, 1'b0);
    step(16'h0C1C, 3'h4, 8, 6'h01, 1'b1);
    step(16'h0E10, 3'h2, 20, 6'h10, 1'b1);
    step(16'h0E10, 3'h0, 8, 6'h01, 1'b1);
    step(16'h0E10, 3'h3, 10, 6'h10, 1'b1);
    step(16'h0E10, 3'h0, 8, 6'h01, 1'b1);
    step(16'h0E10, 3'h5, 20, 6'h01, 1'b0);
    step(16'h0E10, 3'h0, 8, 6'h01, 1'b1);
    for (i = 0; i < 6; i = i + 1) begin
      ship_mode_pin_in = ~ship_mode_pin_in;
      repeat (3) @(posedge sys_clk);
      #1;
    end
    step(16'h0E10, 3'h0, 4, 6'h20, 1'b0);
    step(16'h0E10, 3'h4, 8, 6'h01, 1'b1);
    step(16'h10CC, 3'h4, 30, 6'h02, 1'b0);
    // reset in mid-run must drop the overcharge state
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    step(16'h0E10, 3'h0, 4, 6'h01, 1'b1);
    report_and_stop;
  end
endmodule // tb
